// ==== led_setting_pkg.sv ====
// Purpose: shared constants, types and field layouts of the LED current setting registers
// Assumes: 8-bit registers reached through a serial register pointer
// Notes: current figures are in fixed units named on each constant

package led_setting_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] strobe_one_current_addr = 8'h01;
	localparam logic [7:0] strobe_two_current_addr = 8'h02;
	localparam logic [7:0] torch_current_addr = 8'h03;
	localparam logic [7:0] status_lamp_current_addr = 8'h05;
	localparam logic [7:0] lamp_timing_addr = 8'h07;

	// ------------------------------------------------------------
	// reset values and writable bit masks
	// ------------------------------------------------------------
	localparam logic [7:0] reg_reset_value = 8'h00;
	localparam logic [7:0] strobe_mask = 8'hF8;
	localparam logic [7:0] torch_mask = 8'h77;
	localparam logic [7:0] status_lamp_mask = 8'h7F;
	localparam logic [7:0] lamp_timing_mask = 8'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int strobe_code_lsb = 3;
	localparam int torch_one_lsb = 4;
	localparam int torch_two_lsb = 0;
	localparam int lamp_blink_bit = 6;
	localparam int lamp_ramp_bit = 5;
	localparam int lamp_code_lsb = 0;
	localparam int lamp_on_time_lsb = 4;

	// ------------------------------------------------------------
	// decode figures
	// ------------------------------------------------------------
	// strobe current in units of 10 uA: 23.44 mA per step
	localparam logic [16:0] strobe_step_10ua = 17'h00928;
	localparam logic [16:0] strobe_code30_10ua = 17'h11BD0;
	localparam logic [16:0] strobe_code31_10ua = 17'h124F8;
	// torch current in uA: 15.625 mA per step
	localparam logic [16:0] torch_step_ua = 17'h03D09;
	// status lamp current in units of 0.5 mA
	localparam logic [5:0] lamp_code30_half_ma = 6'h1E;
	localparam logic [5:0] lamp_code31_half_ma = 6'h20;
	// on time base in ms
	localparam logic [10:0] lamp_on_base_ms = 11'h080;

	// ------------------------------------------------------------
	// serial engine
	// ------------------------------------------------------------
	localparam logic [3:0] bits_per_byte = 4'h8;
	localparam logic [3:0] last_tx_bit = 4'h7;

	typedef enum logic [8:0]
	{
		st_idle = 9'h001,
		st_addr = 9'h002,
		st_ack_addr = 9'h004,
		st_ptr = 9'h008,
		st_ack_ptr = 9'h010,
		st_wdata = 9'h020,
		st_ack_wdata = 9'h040,
		st_rdata = 9'h080,
		st_rack = 9'h100
	} serial_state_e;

	typedef struct packed
	{
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;

	typedef struct packed
	{
		logic [4:0] strobe_one_code;
		logic [4:0] strobe_two_code;
		logic [2:0] torch_one_code;
		logic [2:0] torch_two_code;
		logic [4:0] status_lamp_code;
		logic lamp_blink_enable;
		logic lamp_ramp_enable;
		logic [1:0] lamp_on_time_code;
	} led_codes_s;

	typedef struct packed
	{
		logic [16:0] strobe_one_10ua;
		logic [16:0] strobe_two_10ua;
		logic [16:0] torch_one_ua;
		logic [16:0] torch_two_ua;
		logic [5:0] status_lamp_half_ma;
		logic [10:0] lamp_on_time_ms;
	} led_levels_s;

endpackage

// ==== current_decode.sv ====
// Purpose: turns register codes into regulator current levels
// Assumes: codes come from flip-flops on the same clock
// Notes: outputs are registered, one clock behind the codes

`timescale 1ns/10ps
`default_nettype none

module current_decode
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// codes in
	input wire led_setting_pkg::led_codes_s codes,
	// levels out
	output led_setting_pkg::led_levels_s levels
);
	import led_setting_pkg::*;

	logic [4:0] strobe_code [2];
	logic [2:0] torch_code [2];
	logic [16:0] strobe_level [2];
	logic [16:0] torch_level [2];
	logic [5:0] lamp_level;
	logic [10:0] on_ms;

	assign strobe_code[0] = codes.strobe_one_code;
	assign strobe_code[1] = codes.strobe_two_code;
	assign torch_code[0] = codes.torch_one_code;
	assign torch_code[1] = codes.torch_two_code;

	// ------------------------------------------------------------
	// per channel decode
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			logic [16:0] strobe_steps;
			logic [16:0] torch_steps;
			assign strobe_steps = {12'h000, strobe_code[ch]} + 17'h00001;
			assign torch_steps = {14'h0000, torch_code[ch]} + 17'h00001;
			always_comb
			begin
				unique case (strobe_code[ch])
					5'h1E: strobe_level[ch] = strobe_code30_10ua;
					5'h1F: strobe_level[ch] = strobe_code31_10ua;
					default: strobe_level[ch] = 17'(strobe_steps * strobe_step_10ua);
				endcase
			end
			assign torch_level[ch] = 17'(torch_steps * torch_step_ua);
		end
	endgenerate

	// ------------------------------------------------------------
	// status lamp decode
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (codes.status_lamp_code)
			5'h1E: lamp_level = lamp_code30_half_ma;
			5'h1F: lamp_level = lamp_code31_half_ma;
			default: lamp_level = {1'b0, codes.status_lamp_code} + 6'h01;
		endcase
	end

	assign on_ms = lamp_on_base_ms << codes.lamp_on_time_code;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			levels <= '0;
		end
		else
		begin
			levels.strobe_one_10ua <= strobe_level[0];
			levels.strobe_two_10ua <= strobe_level[1];
			levels.torch_one_ua <= torch_level[0];
			levels.torch_two_ua <= torch_level[1];
			levels.status_lamp_half_ma <= lamp_level;
			levels.lamp_on_time_ms <= on_ms;
		end
	end

endmodule

`default_nettype wire

// ==== led_current_setting_regs.sv ====
// Purpose: serial register slave holding the LED current settings
// Assumes: scl and sda arrive asynchronously from the bus pins
// Notes: pointer auto-increments after every data byte, read or write
//
// What this block does
// - strobe one code in bits seven to three
// - strobe two code, same step encoding
// - strobe one register at 0x01, resets 0x00
// - strobe two register at 0x02, resets 0x00
// - listed reserved bits carry no function
// - torch one code in bits six to four
// - torch two code in bits two to zero
// - torch register at 0x03, resets 0x00
// - lamp bit six enables blinking
// - lamp bit five enables current ramping
// - lamp code bits four to zero, half-mA steps
// - lamp bit seven reserved; 0x05, resets 0x00
// - two-bit lamp on time in timing register

`timescale 1ns/10ps
`default_nettype none

module led_current_setting_regs
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// register codes
	output led_setting_pkg::led_codes_s codes,
	// decoded regulator levels
	output led_setting_pkg::led_levels_s levels
);
	import led_setting_pkg::*;

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	generate
		if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hF)
		begin : g_bad_addr
			$error("slave address lies in a reserved address group");
		end
	endgenerate

	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic scl_f;
	logic sda_f;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	serial_state_e state;
	logic [3:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [7:0] pointer;
	logic read_dir;
	logic master_nack;
	reg_write_s wr;
	logic [7:0] strobe_one_current;
	logic [7:0] strobe_two_current;
	logic [7:0] torch_current;
	logic [7:0] status_lamp_current;
	logic [7:0] lamp_timing;
	logic [7:0] rd_data;

	// ------------------------------------------------------------
	// pin synchronisers and filters
	// ------------------------------------------------------------
	// a level counts only once the second and third stages agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
		end
		else
		begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
			if (scl_sync[2] == scl_sync[1])
			begin
				scl_f <= scl_sync[2];
			end
			if (sda_sync[2] == sda_sync[1])
			begin
				sda_f <= sda_sync[2];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_q;
	assign scl_fall = ~scl_f & scl_q;
	assign start_cond = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_cond = scl_f & scl_q & ~sda_q & sda_f;

	// ------------------------------------------------------------
	// serial engine
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= st_idle;
			bit_cnt <= 4'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			pointer <= 8'h00;
			read_dir <= 1'b0;
			master_nack <= 1'b0;
		end
		else if (start_cond)
		begin
			state <= st_addr;
			bit_cnt <= 4'h0;
		end
		else if (stop_cond)
		begin
			state <= st_idle;
			bit_cnt <= 4'h0;
		end
		else
		begin
			unique case (state)
				st_idle:
				begin
					bit_cnt <= 4'h0;
				end
				st_addr, st_ptr, st_wdata:
				begin
					if (scl_rise)
					begin
						rx_shift <= {rx_shift[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
					end
					else if (scl_fall && bit_cnt == bits_per_byte)
					begin
						bit_cnt <= 4'h0;
						if (state == st_addr)
						begin
							read_dir <= rx_shift[0];
							state <= (rx_shift[7:1] == SLAVE_ADDR) ? st_ack_addr : st_idle;
						end
						else if (state == st_ptr)
						begin
							pointer <= rx_shift;
							state <= st_ack_ptr;
						end
						else
						begin
							pointer <= pointer + 8'h01;
							state <= st_ack_wdata;
						end
					end
				end
				st_ack_addr:
				begin
					if (scl_fall)
					begin
						bit_cnt <= 4'h0;
						if (read_dir)
						begin
							tx_shift <= rd_data;
							state <= st_rdata;
						end
						else
						begin
							state <= st_ptr;
						end
					end
				end
				st_ack_ptr, st_ack_wdata:
				begin
					if (scl_fall)
					begin
						state <= st_wdata;
					end
				end
				st_rdata:
				begin
					if (scl_fall)
					begin
						tx_shift <= {tx_shift[6:0], 1'b0};
						if (bit_cnt == last_tx_bit)
						begin
							bit_cnt <= 4'h0;
							pointer <= pointer + 8'h01;
							state <= st_rack;
						end
						else
						begin
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				st_rack:
				begin
					if (scl_rise)
					begin
						master_nack <= sda_f;
					end
					else if (scl_fall)
					begin
						if (master_nack)
						begin
							state <= st_idle;
						end
						else
						begin
							tx_shift <= rd_data;
							state <= st_rdata;
						end
					end
				end
			endcase
		end
	end

	// open-drain data line: only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = (state == st_ack_addr) || (state == st_ack_ptr) || (state == st_ack_wdata)
		|| (state == st_rdata && !tx_shift[7]);

	// write strobe at the end of each received data byte
	always_comb
	begin
		wr.en = (state == st_wdata) && scl_fall && (bit_cnt == bits_per_byte) && !start_cond && !stop_cond;
		wr.addr = pointer;
		wr.data = rx_shift;
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strobe_one_current <= reg_reset_value;
			strobe_two_current <= reg_reset_value;
			torch_current <= reg_reset_value;
			status_lamp_current <= reg_reset_value;
			lamp_timing <= reg_reset_value;
		end
		else if (wr.en)
		begin
			// masked stores keep reserved bits at zero
			unique case (wr.addr)
				strobe_one_current_addr: strobe_one_current <= wr.data & strobe_mask;
				strobe_two_current_addr: strobe_two_current <= wr.data & strobe_mask;
				torch_current_addr: torch_current <= wr.data & torch_mask;
				status_lamp_current_addr: status_lamp_current <= wr.data & status_lamp_mask;
				lamp_timing_addr: lamp_timing <= wr.data & lamp_timing_mask;
				default: ;
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		unique case (pointer)
			strobe_one_current_addr: rd_data = strobe_one_current;
			strobe_two_current_addr: rd_data = strobe_two_current;
			torch_current_addr: rd_data = torch_current;
			status_lamp_current_addr: rd_data = status_lamp_current;
			lamp_timing_addr: rd_data = lamp_timing;
			default: rd_data = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	// reserved bits are masked out above, so they reach no output
	assign codes.strobe_one_code = strobe_one_current[strobe_code_lsb +: 5];
	assign codes.strobe_two_code = strobe_two_current[strobe_code_lsb +: 5];
	assign codes.torch_one_code = torch_current[torch_one_lsb +: 3];
	assign codes.torch_two_code = torch_current[torch_two_lsb +: 3];
	assign codes.status_lamp_code = status_lamp_current[lamp_code_lsb +: 5];
	assign codes.lamp_blink_enable = status_lamp_current[lamp_blink_bit];
	assign codes.lamp_ramp_enable = status_lamp_current[lamp_ramp_bit];
	assign codes.lamp_on_time_code = lamp_timing[lamp_on_time_lsb +: 2];
	// no reserved bit feeds any field above

	current_decode u_decode
	(
		.clk(clk),
		.rst_n(rst_n),
		.codes(codes),
		.levels(levels)
	);

endmodule

`default_nettype wire

// ==== led_current_setting_regs_properties.sv ====
// Purpose: timing and decode checks on the LED current setting block ports
// Assumes: one clock domain, async active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
module led_current_setting_regs_properties
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// settings
	input wire led_setting_pkg::led_codes_s codes,
	input wire led_setting_pkg::led_levels_s levels
);
	import led_setting_pkg::*;
	// ------------------------------------------------------------
	// expected decode
	// ------------------------------------------------------------
	function automatic logic [16:0] strobe_lvl(input logic [4:0] c);
		if (c == 5'h1F)
			return 17'h124F8;
		if (c == 5'h1E)
			return 17'h11BD0;
		return (17'(c) + 17'h00001) * 17'h00928;
	endfunction
	function automatic logic [5:0] lamp_lvl(input logic [4:0] c);
		if (c == 5'h1F)
			return 6'h20;
		if (c >= 5'h1D)
			return 6'h1E;
		return 6'(c) + 6'h01;
	endfunction
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RESET_CLEAR: assert property ($rose(rst_n) |-> codes == '0 && levels == '0)
		else $error("settings not cleared by reset");
	AST_STROBE_ONE_LEVEL: assert property ($past(rst_n) |-> levels.strobe_one_10ua == strobe_lvl($past(codes.strobe_one_code)))
		else $error("strobe one level wrong");
	AST_STROBE_TWO_LEVEL: assert property ($past(rst_n) |-> levels.strobe_two_10ua == strobe_lvl($past(codes.strobe_two_code)))
		else $error("strobe two level wrong");
	AST_TORCH_ONE_LEVEL: assert property ($past(rst_n) |-> levels.torch_one_ua == (17'($past(codes.torch_one_code)) + 17'h00001) * 17'h03D09)
		else $error("torch one level wrong");
	AST_TORCH_TWO_LEVEL: assert property ($past(rst_n) |-> levels.torch_two_ua == (17'($past(codes.torch_two_code)) + 17'h00001) * 17'h03D09)
		else $error("torch two level wrong");
	AST_LAMP_LEVEL: assert property ($past(rst_n) |-> levels.status_lamp_half_ma == lamp_lvl($past(codes.status_lamp_code)))
		else $error("lamp level wrong");
	AST_ON_TIME: assert property (rst_n |=> levels.lamp_on_time_ms == (11'h080 << $past(codes.lamp_on_time_code)))
		else $error("on time wrong");
	AST_CODES_AT_SCL_LOW: assert property ($changed(codes) |-> !scl_in)
		else $error("settings changed outside a byte end");
	cover property ($rose(codes.lamp_blink_enable));
	cover property ($rose(sda_oe));
	cover property (codes.strobe_one_code == 5'h1F);
endmodule
bind led_current_setting_regs led_current_setting_regs_properties led_current_setting_regs_properties_inst
(
	.clk(clk),
	.rst_n(rst_n),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.codes(codes),
	.levels(levels)
);
`default_nettype wire

// ==== i2c_host_model.sv ====
// Purpose: serial bus host driving the register slave
// Assumes: data line resolved with pull-up by the bench
// Notes: lines change on the falling clock edge; bit phases are 6 clocks, start and stop phases 6 or 12
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model
(
	// clock
	input wire logic clk,
	// bus lines
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	// ------------------------------------------------------------
	// bus phases
	// ------------------------------------------------------------
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	// also serves as repeated start
	task automatic start();
		sda_pull = 1'b0;
		hold(6);
		scl = 1'b1;
		hold(12);
		sda_pull = 1'b1;
		hold(12);
		scl = 1'b0;
		hold(6);
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		hold(6);
		scl = 1'b1;
		hold(12);
		sda_pull = 1'b0;
		hold(12);
	endtask
	task automatic xbit(input logic b, output logic r);
		sda_pull = ~b;
		hold(6);
		scl = 1'b1;
		hold(6);
		r = sda;
		hold(6);
		scl = 1'b0;
		hold(6);
	endtask
	// all ones in d releases the line, so the same task reads
	task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			xbit(d[i], q[i]);
		xbit(ack_in, ack);
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for the LED current setting registers
// Assumes: host model drives the bus; expectations built from field layouts
// Notes: runs about 16.5k clocks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import led_setting_pkg::*;
	localparam logic [6:0] dev = 7'h2A;
	logic clk, rst_n, scl, sda_pull, sda_out, sda_oe, sda, a;
	logic [7:0] q;
	led_codes_s codes;
	led_levels_s levels;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	assign sda = ~(sda_pull | (sda_oe & ~sda_out));
	led_current_setting_regs #(.SLAVE_ADDR(dev)) led_current_setting_regs_inst
	(
		.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.codes(codes), .levels(levels)
	);
	i2c_host_model i2c_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tx(input logic [7:0] d);
		i2c_host_model_inst.xbyte(d, 1'b1, q, a);
		check(a, 1'b0);
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		i2c_host_model_inst.start();
		tx({dev, 1'b0});
		tx(ptr);
		tx(d);
		i2c_host_model_inst.stop();
	endtask
	task automatic rd_open(input logic [7:0] ptr);
		i2c_host_model_inst.start();
		tx({dev, 1'b0});
		tx(ptr);
		i2c_host_model_inst.start();
		tx({dev, 1'b1});
	endtask
	task automatic rd(input logic [7:0] ptr);
		rd_open(ptr);
		i2c_host_model_inst.xbyte(8'hFF, 1'b1, q, a);
		i2c_host_model_inst.stop();
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(codes, 26'h0);
		rd(8'h01);
		check(q, 8'h00);
		rd(8'h02);
		check(q, 8'h00);
		rd(8'h03);
		check(q, 8'h00);
		rd(8'h05);
		check(q, 8'h00);
		wr(8'h04, 8'hFF);
		rd(8'h04);
		check(q, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_burst();
		logic [7:0] exp [3] = '{8'hF8, 8'hF0, 8'h77};
		i2c_host_model_inst.start();
		tx({dev, 1'b0});
		tx(8'h01);
		tx(8'hFF);
		tx(8'hF7);
		tx(8'hFF);
		i2c_host_model_inst.stop();
		check(codes.strobe_one_code, 5'h1F);
		check(levels.strobe_one_10ua, 17'h124F8);
		check(codes.strobe_two_code, 5'h1E);
		check(levels.strobe_two_10ua, 17'h11BD0);
		check(levels.torch_one_ua, 17'h1E848);
		rd_open(8'h01);
		for (int i = 0; i < 3; i++)
		begin
			i2c_host_model_inst.xbyte(8'hFF, i == 2, q, a);
			check(q, exp[i]);
		end
		i2c_host_model_inst.stop();
		$display("t_burst done");
	endtask
	task automatic t_torch();
		wr(8'h03, 8'h5A);
		check(codes.torch_one_code, 3'h5);
		check(codes.torch_two_code, 3'h2);
		check(levels.torch_two_ua, 17'h0B71B);
		check(levels.torch_one_ua, 17'h16E36);
		rd(8'h03);
		check(q, 8'h52);
		$display("t_torch done");
	endtask
	task automatic t_lamp();
		wr(8'h05, 8'hDE);
		check(codes.lamp_blink_enable, 1'b1);
		check(codes.lamp_ramp_enable, 1'b0);
		check(levels.status_lamp_half_ma, 6'h1E);
		rd(8'h05);
		check(q, 8'h5E);
		wr(8'h05, 8'hBF);
		check(codes.lamp_blink_enable, 1'b0);
		check(codes.lamp_ramp_enable, 1'b1);
		check(levels.status_lamp_half_ma, 6'h20);
		rd(8'h05);
		check(q, 8'h3F);
		$display("t_lamp done");
	endtask
	task automatic t_timing();
		wr(8'h07, 8'hFF);
		check(codes.lamp_on_time_code, 2'h3);
		check(levels.lamp_on_time_ms, 11'h400);
		rd(8'h07);
		check(q, 8'h30);
		$display("t_timing done");
	endtask
	task automatic t_other();
		i2c_host_model_inst.start();
		i2c_host_model_inst.xbyte({7'h2B, 1'b0}, 1'b1, q, a);
		check(a, 1'b1);
		i2c_host_model_inst.xbyte(8'h01, 1'b1, q, a);
		check(a, 1'b1);
		i2c_host_model_inst.xbyte(8'h00, 1'b1, q, a);
		check(a, 1'b1);
		i2c_host_model_inst.stop();
		check(codes.strobe_one_code, 5'h1F);
		$display("t_other done");
	endtask
	task automatic t_mid_reset();
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		check(codes, 26'h0);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		check(levels.lamp_on_time_ms, 11'h080);
		check(levels.strobe_one_10ua, 17'h00928);
		check(levels.torch_two_ua, 17'h03D09);
		check(levels.status_lamp_half_ma, 6'h01);
		rd(8'h01);
		check(q, 8'h00);
		$display("t_mid_reset done");
	endtask
	// ------------------------------------------------------------
	// clock, reset, sequence, timeout
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		t_reset();
		t_burst();
		t_torch();
		t_lamp();
		t_timing();
		t_other();
		t_mid_reset();
		summarize();
	end
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			err_total++;
			summarize();
		end
	end
endmodule
`default_nettype wire
